// ==== core/tpr_consts.svh ====
`ifndef TPR_CONSTS_SVH
`define TPR_CONSTS_SVH

// ----------------------------------------------------------------
// reset release timing
// ----------------------------------------------------------------
`define TPR_RST_RELEASE_CYCLES 16

// ----------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------
`define TPR_IR_WIDTH   4
`define TPR_IR_IDCODE  4'h1
`define TPR_IR_BYPASS  4'hf
`define TPR_IR_CAPTURE 4'h1
// arbitrary identification value
`define TPR_IDCODE_VALUE 32'h0000_0001
`define TPR_DR_WIDTH   32

// ----------------------------------------------------------------
// port d pin positions (port_d_bit0_alt .. port_d_bit4_alt)
// ----------------------------------------------------------------
`define TPR_PIN_TDI   0
`define TPR_PIN_TDO   1
`define TPR_PIN_TCK   2
`define TPR_PIN_TMS   3
`define TPR_PIN_RST   4
`define TPR_PORT_D_W  5
`define TPR_PORT_A_W  2

`endif

// ==== core/tpr_pkg.sv ====
`default_nettype none

package tpr_pkg;

  // ----------------------------------------------------------------
  // tap controller states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    TAP_RESET     = 16'h0001,
    TAP_IDLE      = 16'h0002,
    TAP_SEL_DR    = 16'h0004,
    TAP_CAP_DR    = 16'h0008,
    TAP_SHIFT_DR  = 16'h0010,
    TAP_EXIT1_DR  = 16'h0020,
    TAP_PAUSE_DR  = 16'h0040,
    TAP_EXIT2_DR  = 16'h0080,
    TAP_UPD_DR    = 16'h0100,
    TAP_SEL_IR    = 16'h0200,
    TAP_CAP_IR    = 16'h0400,
    TAP_SHIFT_IR  = 16'h0800,
    TAP_EXIT1_IR  = 16'h1000,
    TAP_PAUSE_IR  = 16'h2000,
    TAP_EXIT2_IR  = 16'h4000,
    TAP_UPD_IR    = 16'h8000
  } tpr_tap_state_t;

  // pad drive: output value and active-low output enable
  typedef struct packed {
    logic out;
    logic oe_n;
  } tpr_pad_t;

  // per-pin software configuration
  typedef struct packed {
    logic periph_en;   // peripheral enable bit
    logic periph_sel;  // peripheral select bit
    logic dir;         // 1 = output
    logic out;         // gpio output value
  } tpr_pin_cfg_t;

endpackage

`default_nettype wire

// ==== core/tpr_reset_ctl.sv ====
`include "tpr_consts.svh"
`default_nettype none

// ----------------------------------------------------------------
// internal reset generator
// ----------------------------------------------------------------
module tpr_reset_ctl #(
  parameter int RELEASE_CYCLES = `TPR_RST_RELEASE_CYCLES
) (
  input  wire logic clk,                 // system clock
  input  wire logic reset,               // power-on reset
  input  wire logic ext_reset_n,         // synchronised reset pin
  input  wire logic pin_is_gpio,         // reset pin in port mode
  input  wire logic watchdog_reset_src,  // watchdog reset request
  input  wire logic sw_reset_req,        // software reset request
  output logic      rst_o                // internal reset
);
  localparam int CW = $clog2(RELEASE_CYCLES + 1);

  logic [CW-1:0] cnt_reg;
  logic          rst_reg;
  logic          pin_src;
  logic          any_src;

  // pin counts only in reset function
  assign pin_src = ~ext_reset_n & ~pin_is_gpio;
  assign any_src = pin_src | watchdog_reset_src | sw_reset_req;
  assign rst_o   = rst_reg;

  // hold while any source, release after quiet count
  always_ff @(posedge clk) begin
    if (reset || any_src) begin
      cnt_reg <= '0;
      rst_reg <= 1'b1;
    end else if (rst_reg) begin
      if (cnt_reg == CW'(RELEASE_CYCLES - 1)) rst_reg <= 1'b0;
      else cnt_reg <= cnt_reg + CW'(1);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [CW:0] quiet_hlp;
  always_ff @(posedge clk) begin
    if (reset || any_src) quiet_hlp <= '0;
    else if (rst_reg) quiet_hlp <= quiet_hlp + (CW+1)'(1);
  end

  property p_pin_holds;
    @(posedge clk) disable iff (reset) pin_src |=> rst_o ##1 rst_o;
  endproperty
  a_pin_holds: assert property (p_pin_holds) else $error("reset pin low did not hold reset");

  property p_release_count;
    @(posedge clk) disable iff (reset) $fell(rst_o) |-> $past(quiet_hlp) == (CW+1)'(RELEASE_CYCLES - 1);
  endproperty
  a_release_count: assert property (p_release_count) else $error("reset released at wrong count");

  property p_pin_ignored;
    @(posedge clk) disable iff (reset)
      (!rst_o && pin_is_gpio && !watchdog_reset_src && !sw_reset_req) |=> !rst_o;
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("port-mode pin caused reset");

endmodule

`default_nettype wire

// ==== core/tpr_top.sv ====
`include "tpr_consts.svh"
`default_nettype none

module tpr_top #(
  parameter int                 RELEASE_CYCLES = `TPR_RST_RELEASE_CYCLES,
  parameter logic [`TPR_DR_WIDTH-1:0] IDCODE   = `TPR_IDCODE_VALUE  // arbitrary value
) (
  input  wire logic                clk,                                // 250 mhz clock
  input  wire logic                reset,                              // power-on reset
  input  wire logic [`TPR_PORT_D_W-1:0] port_d_pad_in,                 // port d pin levels
  output tpr_pkg::tpr_pad_t [`TPR_PORT_D_W-1:0] port_d_pad,            // port d pin drive
  input  wire tpr_pkg::tpr_pin_cfg_t [`TPR_PORT_D_W-1:0] port_d_cfg,   // port d config
  output logic [`TPR_PORT_D_W-1:0] port_d_gpio_in,                     // port d readback
  input  wire logic [`TPR_PORT_A_W-1:0] port_a_pad_in,                 // port a pin levels
  output tpr_pkg::tpr_pad_t [`TPR_PORT_A_W-1:0] port_a_pad,            // port a pin drive
  input  wire tpr_pkg::tpr_pin_cfg_t [`TPR_PORT_A_W-1:0] port_a_cfg,   // port a config
  output logic [`TPR_PORT_A_W-1:0] port_a_gpio_in,                     // port a readback
  input  wire logic                comparator_c_out,                   // comparator c result
  input  wire logic                watchdog_reset_src,                 // watchdog reset
  input  wire logic                sw_reset_req,                       // software reset
  output logic                     sys_reset_out                       // internal reset
);
  localparam int IRW = `TPR_IR_WIDTH;
  localparam int DRW = `TPR_DR_WIDTH;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [`TPR_PORT_D_W-1:0] d_meta_reg;
  logic [`TPR_PORT_D_W-1:0] d_sync_reg;
  logic [`TPR_PORT_A_W-1:0] a_meta_reg;
  logic [`TPR_PORT_A_W-1:0] a_sync_reg;

  // two flops per pin, reset pin included
  always_ff @(posedge clk) begin
    d_meta_reg <= port_d_pad_in;
    d_sync_reg <= d_meta_reg;
    a_meta_reg <= port_a_pad_in;
    a_sync_reg <= a_meta_reg;
  end

  assign port_d_gpio_in = d_sync_reg;
  assign port_a_gpio_in = a_sync_reg;

  // ----------------------------------------------------------------
  // reset
  // ----------------------------------------------------------------
  logic ext_reset_n;
  logic rst_pin_gpio;
  logic sys_rst;

  assign ext_reset_n  = d_sync_reg[`TPR_PIN_RST];
  assign rst_pin_gpio = port_d_cfg[`TPR_PIN_RST].periph_en & port_d_cfg[`TPR_PIN_RST].periph_sel;

  tpr_reset_ctl #(
    .RELEASE_CYCLES (RELEASE_CYCLES)
  ) u_reset (
    .clk                (clk),
    .reset              (reset),
    .ext_reset_n        (ext_reset_n),
    .pin_is_gpio        (rst_pin_gpio),
    .watchdog_reset_src (watchdog_reset_src),
    .sw_reset_req       (sw_reset_req),
    .rst_o              (sys_rst)
  );

  assign sys_reset_out = sys_rst;

  // ----------------------------------------------------------------
  // alternate function selection
  // ----------------------------------------------------------------
  logic [`TPR_PORT_D_W-1:0] d_alt;
  logic [`TPR_PORT_A_W-1:0] a_alt;
  logic [`TPR_PORT_A_W-1:0] a_dir;

  // alternate only with both bits, never during reset
  genvar gi;
  generate
    for (gi = 0; gi < `TPR_PORT_D_W; gi++) begin : g_dalt
      assign d_alt[gi] = port_d_cfg[gi].periph_en & port_d_cfg[gi].periph_sel & ~sys_rst;
    end
    for (gi = 0; gi < `TPR_PORT_A_W; gi++) begin : g_aalt
      assign a_alt[gi] = port_a_cfg[gi].periph_en & port_a_cfg[gi].periph_sel & ~sys_rst;
      assign a_dir[gi] = port_a_cfg[gi].dir & ~sys_rst;
    end
  endgenerate

  // ----------------------------------------------------------------
  // test clock edges and tap inputs
  // ----------------------------------------------------------------
  logic tck_eff;
  logic tms_eff;
  logic tdi_eff;
  logic tck_prev_reg;
  logic tck_rise;
  logic tck_fall;

  // port-mode pins read as pulled-up idle
  assign tck_eff  = d_alt[`TPR_PIN_TCK] | d_sync_reg[`TPR_PIN_TCK];
  assign tms_eff  = d_alt[`TPR_PIN_TMS] | d_sync_reg[`TPR_PIN_TMS];
  assign tdi_eff  = d_alt[`TPR_PIN_TDI] | d_sync_reg[`TPR_PIN_TDI];
  assign tck_rise = tck_eff & ~tck_prev_reg;
  assign tck_fall = ~tck_eff & tck_prev_reg;

  // tracks the pin through reset too, so no false edge follows release while the clock pin is not in port mode
  always_ff @(posedge clk) begin
    tck_prev_reg <= tck_eff;
  end

  // ----------------------------------------------------------------
  // tap state machine
  // ----------------------------------------------------------------
  tpr_pkg::tpr_tap_state_t state_reg;
  tpr_pkg::tpr_tap_state_t state_next;

  // next state from mode select
  always_comb begin
    case (state_reg)
      tpr_pkg::TAP_RESET:    state_next = tms_eff ? tpr_pkg::TAP_RESET    : tpr_pkg::TAP_IDLE;
      tpr_pkg::TAP_IDLE:     state_next = tms_eff ? tpr_pkg::TAP_SEL_DR   : tpr_pkg::TAP_IDLE;
      tpr_pkg::TAP_SEL_DR:   state_next = tms_eff ? tpr_pkg::TAP_SEL_IR   : tpr_pkg::TAP_CAP_DR;
      tpr_pkg::TAP_CAP_DR:   state_next = tms_eff ? tpr_pkg::TAP_EXIT1_DR : tpr_pkg::TAP_SHIFT_DR;
      tpr_pkg::TAP_SHIFT_DR: state_next = tms_eff ? tpr_pkg::TAP_EXIT1_DR : tpr_pkg::TAP_SHIFT_DR;
      tpr_pkg::TAP_EXIT1_DR: state_next = tms_eff ? tpr_pkg::TAP_UPD_DR   : tpr_pkg::TAP_PAUSE_DR;
      tpr_pkg::TAP_PAUSE_DR: state_next = tms_eff ? tpr_pkg::TAP_EXIT2_DR : tpr_pkg::TAP_PAUSE_DR;
      tpr_pkg::TAP_EXIT2_DR: state_next = tms_eff ? tpr_pkg::TAP_UPD_DR   : tpr_pkg::TAP_SHIFT_DR;
      tpr_pkg::TAP_UPD_DR:   state_next = tms_eff ? tpr_pkg::TAP_SEL_DR   : tpr_pkg::TAP_IDLE;
      tpr_pkg::TAP_SEL_IR:   state_next = tms_eff ? tpr_pkg::TAP_RESET    : tpr_pkg::TAP_CAP_IR;
      tpr_pkg::TAP_CAP_IR:   state_next = tms_eff ? tpr_pkg::TAP_EXIT1_IR : tpr_pkg::TAP_SHIFT_IR;
      tpr_pkg::TAP_SHIFT_IR: state_next = tms_eff ? tpr_pkg::TAP_EXIT1_IR : tpr_pkg::TAP_SHIFT_IR;
      tpr_pkg::TAP_EXIT1_IR: state_next = tms_eff ? tpr_pkg::TAP_UPD_IR   : tpr_pkg::TAP_PAUSE_IR;
      tpr_pkg::TAP_PAUSE_IR: state_next = tms_eff ? tpr_pkg::TAP_EXIT2_IR : tpr_pkg::TAP_PAUSE_IR;
      tpr_pkg::TAP_EXIT2_IR: state_next = tms_eff ? tpr_pkg::TAP_UPD_IR   : tpr_pkg::TAP_SHIFT_IR;
      tpr_pkg::TAP_UPD_IR:   state_next = tms_eff ? tpr_pkg::TAP_SEL_DR   : tpr_pkg::TAP_IDLE;
      default:               state_next = tpr_pkg::TAP_RESET;
    endcase
  end

  // advance on rising test clock
  always_ff @(posedge clk) begin
    if (sys_rst) state_reg <= tpr_pkg::TAP_RESET;
    else if (tck_rise) state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // instruction and data shift paths
  // ----------------------------------------------------------------
  logic [IRW-1:0] ir_shift_reg;
  logic [IRW-1:0] ir_reg;
  logic [DRW-1:0] dr_shift_reg;
  logic           sel_id;
  logic           in_shift;

  assign sel_id   = (ir_reg == `TPR_IR_IDCODE);
  assign in_shift = (state_reg == tpr_pkg::TAP_SHIFT_IR) | (state_reg == tpr_pkg::TAP_SHIFT_DR);

  // capture, shift and update on rising test clock
  always_ff @(posedge clk) begin
    if (sys_rst || (state_reg == tpr_pkg::TAP_RESET)) begin
      ir_shift_reg <= '0;
      ir_reg       <= `TPR_IR_IDCODE;
      dr_shift_reg <= '0;
    end else if (tck_rise) begin
      case (state_reg)
        tpr_pkg::TAP_CAP_IR:   ir_shift_reg <= `TPR_IR_CAPTURE;
        tpr_pkg::TAP_SHIFT_IR: ir_shift_reg <= {tdi_eff, ir_shift_reg[IRW-1:1]};
        tpr_pkg::TAP_UPD_IR:   ir_reg <= ir_shift_reg;
        tpr_pkg::TAP_CAP_DR:   dr_shift_reg <= sel_id ? IDCODE : '0;
        tpr_pkg::TAP_SHIFT_DR: begin
          if (sel_id) dr_shift_reg <= {tdi_eff, dr_shift_reg[DRW-1:1]};
          else dr_shift_reg[0] <= tdi_eff;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // test data output, falling edge
  // ----------------------------------------------------------------
  logic tdo_reg;
  logic tdo_oe_n_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tdo_reg      <= 1'b0;
      tdo_oe_n_reg <= 1'b1;
    end else if (tck_fall) begin
      tdo_reg      <= (state_reg == tpr_pkg::TAP_SHIFT_IR) ? ir_shift_reg[0] : dr_shift_reg[0];
      tdo_oe_n_reg <= ~in_shift;
    end
  end

  // ----------------------------------------------------------------
  // pad drive
  // ----------------------------------------------------------------
  tpr_pkg::tpr_pad_t [`TPR_PORT_D_W-1:0] d_pad_next;
  tpr_pkg::tpr_pad_t [`TPR_PORT_D_W-1:0] d_pad_reg;
  tpr_pkg::tpr_pad_t [`TPR_PORT_A_W-1:0] a_pad_next;
  tpr_pkg::tpr_pad_t [`TPR_PORT_A_W-1:0] a_pad_reg;
  logic                                 od_low;

  // reset pin in port mode: open-drain, pulls low only
  assign od_low = port_d_cfg[`TPR_PIN_RST].dir & ~port_d_cfg[`TPR_PIN_RST].out;

  generate
    for (gi = 0; gi < `TPR_PORT_D_W; gi++) begin : g_dpad
      if (gi == `TPR_PIN_TDO) begin : g_tdo
        assign d_pad_next[gi] = d_alt[gi] ? {port_d_cfg[gi].out, ~port_d_cfg[gi].dir}
                                          : {tdo_reg, tdo_oe_n_reg};
      end else if (gi == `TPR_PIN_RST) begin : g_rst
        assign d_pad_next[gi] = d_alt[gi] ? {1'b0, ~od_low} : 2'b01;
      end else begin : g_in
        assign d_pad_next[gi] = d_alt[gi] ? {port_d_cfg[gi].out, ~port_d_cfg[gi].dir}
                                          : 2'b01;
      end
    end
    for (gi = 0; gi < `TPR_PORT_A_W; gi++) begin : g_apad
      if (gi == 0) begin : g_cmp
        assign a_pad_next[gi] = a_alt[gi] ? {comparator_c_out, 1'b0}
                                          : {port_a_cfg[gi].out, ~a_dir[gi]};
      end else begin : g_gpio
        assign a_pad_next[gi] = {port_a_cfg[gi].out, ~a_dir[gi]};
      end
    end
  endgenerate

  // registered pad drive, released at reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      d_pad_reg <= {`TPR_PORT_D_W{2'b01}};
      a_pad_reg <= {`TPR_PORT_A_W{2'b01}};
    end else begin
      d_pad_reg <= d_pad_next;
      a_pad_reg <= a_pad_next;
    end
  end

  assign port_d_pad = d_pad_reg;
  assign port_a_pad = a_pad_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_fall_in_shift;
    tck_fall && in_shift;
  endsequence

  property p_tdo_drive;
    @(posedge clk) disable iff (reset || sys_rst) tck_fall |=> (tdo_oe_n_reg == !$past(in_shift));
  endproperty
  a_tdo_drive: assert property (p_tdo_drive) else $error("tdo enable not tied to shift state");

  property p_tdo_edge;
    @(posedge clk) disable iff (reset || sys_rst) $changed(tdo_reg) |-> $past(tck_fall);
  endproperty
  a_tdo_edge: assert property (p_tdo_edge) else $error("tdo changed off falling edge");

  property p_tdo_pad;
    @(posedge clk) disable iff (reset || sys_rst)
      (s_fall_in_shift ##1 !d_alt[`TPR_PIN_TDO]) |=> !port_d_pad[`TPR_PIN_TDO].oe_n;
  endproperty
  a_tdo_pad: assert property (p_tdo_pad) else $error("tdo pad not driven in shift");

  property p_bypass_sample;
    @(posedge clk) disable iff (reset || sys_rst)
      (tck_rise && state_reg == tpr_pkg::TAP_SHIFT_DR && !sel_id) |=> dr_shift_reg[0] == $past(tdi_eff);
  endproperty
  a_bypass_sample: assert property (p_bypass_sample) else $error("tdi not sampled on rising edge");

  property p_tms_steer;
    @(posedge clk) disable iff (reset || sys_rst)
      (tck_rise && state_reg == tpr_pkg::TAP_IDLE) |=> state_reg == ($past(tms_eff) ? tpr_pkg::TAP_SEL_DR
                                                                                     : tpr_pkg::TAP_IDLE);
  endproperty
  a_tms_steer: assert property (p_tms_steer) else $error("tms did not steer tap");

  property p_state_hold;
    @(posedge clk) disable iff (reset || sys_rst) !tck_rise |=> $stable(state_reg);
  endproperty
  a_state_hold: assert property (p_state_hold) else $error("tap moved without rising edge");

  property p_default_pins;
    @(posedge clk) disable iff (reset) sys_rst |=> port_d_pad[`TPR_PIN_TDI].oe_n && port_a_pad[0].oe_n
                                                   && port_a_pad[1].oe_n;
  endproperty
  a_default_pins: assert property (p_default_pins) else $error("pins not inputs after reset");

  property p_od_only;
    @(posedge clk) disable iff (reset) !port_d_pad[`TPR_PIN_RST].oe_n |-> !port_d_pad[`TPR_PIN_RST].out;
  endproperty
  a_od_only: assert property (p_od_only) else $error("reset pin driven high");

  property p_comp_out;
    @(posedge clk) disable iff (reset || sys_rst)
      a_alt[0] |=> port_a_pad[0].out == $past(comparator_c_out) && !port_a_pad[0].oe_n;
  endproperty
  a_comp_out: assert property (p_comp_out) else $error("comparator output not on pin");

  property p_alt_idle;
    @(posedge clk) disable iff (reset || sys_rst) d_alt[`TPR_PIN_TCK] [*2] |-> !tck_rise;
  endproperty
  a_alt_idle: assert property (p_alt_idle) else $error("tap clocked from port-mode pin");

  property p_no_alt_without_sel;
    @(posedge clk) disable iff (reset)
      !(port_d_cfg[`TPR_PIN_TDO].periph_en && port_d_cfg[`TPR_PIN_TDO].periph_sel) ##1 !sys_rst
        |-> port_d_pad[`TPR_PIN_TDO].oe_n == $past(tdo_oe_n_reg);
  endproperty
  a_no_alt_without_sel: assert property (p_no_alt_without_sel) else $error("alt active without select");

endmodule

`default_nettype wire

// ==== test/tpr_jtag_host.sv ====
`default_nettype none

// ------------------------------------------------
// test port controller model
// ------------------------------------------------
module tpr_jtag_host (
  output logic      tck,      // test clock
  output logic      tms,      // mode select
  output logic      tdi,      // test data in
  input  wire logic tdo,      // resolved tdo pin
  input  wire logic tdo_oe_n  // tdo enable, low active
);
  timeunit 1ns;
  timeprecision 100ps;

  // lines at pull-up idle, clock parked low
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one 32 ns clock; data set on fall, tdo taken late in high phase
  task automatic step(input logic m, input logic d, output logic o, output logic oen);
    tck = 1'b0;
    tms = m;
    tdi = d;
    #16 tck = 1'b1;
    #15 o = tdo;
    oen = tdo_oe_n;
    #1 tck = 1'b0;
  endtask

  // release data lines to pull-up between frames
  task automatic park;
    tms = 1'b1;
    tdi = 1'b1;
  endtask
endmodule

`default_nettype wire

// ==== test/tb.sv ====
`include "tpr_consts.svh"
`default_nettype none

// ------------------------------------------------
// bench top
// ------------------------------------------------
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int          R  = 4;
  localparam logic [31:0] ID = 32'h5a3c_96e1;  // arbitrary value
  logic                                       clk, reset, comp, wdog, swr, ext_rst_n, sys;
  wire logic                                  h_tck, h_tms, h_tdi;
  logic [`TPR_PORT_D_W-1:0]                   pd_pin, pd_gin, pd_drv;
  logic [`TPR_PORT_A_W-1:0]                   pa_pin, pa_gin, pa_drv;
  tpr_pkg::tpr_pad_t [`TPR_PORT_D_W-1:0]      pd_pad;
  tpr_pkg::tpr_pad_t [`TPR_PORT_A_W-1:0]      pa_pad;
  tpr_pkg::tpr_pin_cfg_t [`TPR_PORT_D_W-1:0]  pd_cfg;
  tpr_pkg::tpr_pin_cfg_t [`TPR_PORT_A_W-1:0]  pa_cfg;
  logic [15:0]                                rnd;
  logic [63:0]                                o, e;
  int                                         err_count, checks_done, cycles;
  bit                                         q[$];

  // pin levels: pad drive wins, else far side or pull-up
  assign pd_drv = {ext_rst_n, h_tms, h_tck, 1'b1, h_tdi};
  always_comb begin
    for (int i = 0; i < `TPR_PORT_D_W; i++) pd_pin[i] = (pd_pad[i].oe_n === 1'b0) ? pd_pad[i].out : pd_drv[i];
    for (int i = 0; i < `TPR_PORT_A_W; i++) pa_pin[i] = (pa_pad[i].oe_n === 1'b0) ? pa_pad[i].out : pa_drv[i];
  end

  tpr_top #(.RELEASE_CYCLES(R), .IDCODE(ID)) DUT (
    .clk(clk), .reset(reset), .port_d_pad_in(pd_pin), .port_d_pad(pd_pad), .port_d_cfg(pd_cfg),
    .port_d_gpio_in(pd_gin), .port_a_pad_in(pa_pin), .port_a_pad(pa_pad), .port_a_cfg(pa_cfg),
    .port_a_gpio_in(pa_gin), .comparator_c_out(comp), .watchdog_reset_src(wdog),
    .sw_reset_req(swr), .sys_reset_out(sys)
  );

  tpr_jtag_host host (.tck(h_tck), .tms(h_tms), .tdi(h_tdi), .tdo(pd_pin[`TPR_PIN_TDO]),
    .tdo_oe_n(pd_pad[`TPR_PIN_TDO].oe_n));

  // clock and hang guard
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      complete_run();
    end
  end

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic chk_flag(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %0b seen %0b", name, exp, got);
    end
  endtask

  task automatic chk_data(input string name, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // count edges until internal reset drops
  task automatic wait_low(input int lo, input int hi);
    int c = 0;
    while (sys !== 1'b0 && c <= hi) begin
      tick(1);
      c++;
    end
    chk_flag("release count", 1'b1, c >= lo && c <= hi);
  endtask

  // one frame, tms and tdi lsb first
  task automatic scan(input int nb, input logic [63:0] m, input logic [63:0] d);
    o = '0;
    e = '0;
    #0.7;
    for (int i = 0; i < nb; i++) host.step(m[i], d[i], o[i], e[i]);
    host.park();
    tick(1);
  endtask

  task automatic complete_run;
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    comp = 1'b0;
    wdog = 1'b0;
    swr = 1'b0;
    ext_rst_n = 1'b1;
    pd_cfg = '0;
    pa_cfg = '0;
    rnd = 16'h000e;
    pa_drv = rnd[1:0];
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    wait_low(R, R + 1);
    chk_data("port a enables", 64'h3, 64'({pa_pad[1].oe_n, pa_pad[0].oe_n}));
    chk_data("port a readback", 64'(pa_pin), 64'(pa_gin));
    // mode pin in port mode: tap must stay in reset
    pd_cfg[`TPR_PIN_TMS] = 4'hc;
    scan(43, 64'h0000_0300_0000_005f, 64'(rnd));
    chk_data("tdo enables idle", 64'h7ff_ffff_ffff, 64'(e[42:0]));
    pd_cfg[`TPR_PIN_TMS] = 4'h0;
    // clock pin in port mode: tms path to shift must not be walked
    pd_cfg[`TPR_PIN_TCK] = 4'hc;
    scan(8, 64'h2, 64'h0);
    chk_data("tdo enables gated", 64'hff, 64'(e[7:0]));
    pd_cfg[`TPR_PIN_TCK] = 4'h0;
    tick(2);
    // id read straight after reset
    rnd = lfsr(rnd);
    scan(43, 64'h0000_0300_0000_005f, 64'(rnd));
    chk_data("id value", 64'(ID), 64'(o[40:9]));
    chk_data("tdo enables", 64'h0000_0600_0000_01ff, 64'(e[42:0]));
    // load bypass, check capture value
    scan(10, 64'h183, 64'hf0);
    chk_data("ir capture", 64'h1, 64'(o[7:4]));
    chk_data("ir enables", 64'h30f, 64'(e[9:0]));
    rnd = lfsr(rnd);
    scan(21, 64'hc_0001, 64'(rnd) << 3);
    q.push_back(1'b0);
    for (int k = 0; k < 16; k++) q.push_back(rnd[k]);
    for (int k = 0; k < 16; k++) chk_flag("bypass bit", q[k], o[3 + k]);
    // comparator alt function and half-set selections
    for (int k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      comp = rnd[0];
      pa_drv = rnd[2:1];
      pa_cfg[0] = 4'hc;
      tick(2);
      chk_flag("cmp out", comp, pa_pad[0].out);
      chk_flag("cmp enable", 1'b0, pa_pad[0].oe_n);
      pa_cfg[0] = {k == 0, k == 1, 1'b1, ~comp};
      tick(2);
      chk_flag("gpio out", ~comp, pa_pad[0].out);
    end
    pa_cfg = '0;
    // reset pin in reset function
    ext_rst_n = 1'b0;
    tick(1);
    chk_flag("sys reset early", 1'b0, sys);
    tick(3);
    chk_flag("sys reset", 1'b1, sys);
    tick(8);
    chk_flag("sys reset held", 1'b1, sys);
    ext_rst_n = 1'b1;
    wait_low(R + 1, R + 4);
    // reset pin in port mode
    pd_cfg[`TPR_PIN_RST] = 4'hc;
    ext_rst_n = 1'b0;
    tick(6);
    chk_flag("pin ignored", 1'b0, sys);
    chk_flag("pin readback", 1'b0, pd_gin[`TPR_PIN_RST]);
    pd_cfg[`TPR_PIN_RST] = 4'he;
    tick(2);
    chk_data("open drain low", 64'h0, 64'(pd_pad[`TPR_PIN_RST]));
    pd_cfg[`TPR_PIN_RST] = 4'hf;
    tick(2);
    chk_data("open drain high", 64'h1, 64'(pd_pad[`TPR_PIN_RST]));
    for (int s = 0; s < 2; s++) begin
      {swr, wdog} = 2'(1 << s);
      tick(2);
      chk_flag("source reset", 1'b1, sys);
      {swr, wdog} = 2'b00;
      wait_low(R, R + 2);
    end
    ext_rst_n = 1'b1;
    complete_run();
  end
endmodule

`default_nettype wire
